// ===== inc/sjtap_regs.vh
`ifndef SJTAP_REGS_VH
`define SJTAP_REGS_VH
// instruction codes, three bits
`define SJTAP_IR_W        3
`define SJTAP_IR_EXTEST   3'h0
`define SJTAP_IR_IDCODE   3'h1
`define SJTAP_IR_SAMPLEZ  3'h2
`define SJTAP_IR_SAMPLE   3'h4
`define SJTAP_IR_BYPASS   3'h7
// capture pattern in the two low instruction bits
`define SJTAP_IR_CAPTURE  2'h1
`define SJTAP_ID_W        32
// tap states, binary coded
`define SJTAP_S_RESET     4'h0
`define SJTAP_S_IDLE      4'h1
`define SJTAP_S_SEL_DR    4'h2
`define SJTAP_S_CAP_DR    4'h3
`define SJTAP_S_SH_DR     4'h4
`define SJTAP_S_EX1_DR    4'h5
`define SJTAP_S_PAU_DR    4'h6
`define SJTAP_S_EX2_DR    4'h7
`define SJTAP_S_UPD_DR    4'h8
`define SJTAP_S_SEL_IR    4'h9
`define SJTAP_S_CAP_IR    4'hA
`define SJTAP_S_SH_IR     4'hB
`define SJTAP_S_EX1_IR    4'hC
`define SJTAP_S_PAU_IR    4'hD
`define SJTAP_S_EX2_IR    4'hE
`define SJTAP_S_UPD_IR    4'hF
`endif

// ===== verilog/sjtap_sync.v
`timescale 1ns/100ps
`default_nettype none
module sjtap_sync #(
  parameter RST_VAL = 1'b0
) (
  input  wire clk,
  input  wire rst_n,
  input  wire d,
  output reg  q
);
  reg meta;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= RST_VAL;
      q    <= RST_VAL;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule
`default_nettype wire

// ===== verilog/sjtap_port.v
// Functional notes
// - tap follows standard sixteen-state controller
// - inputs on tck rise, tdo and tdo enable on fall
// - tms steers fsm, floats high
// - tdi floats high when unused
// - instruction selects the data register
// - tdi enters selected register msb
// - tdo from lsb, changes on fall
// - tdo enable follows controller state
// - five tms-high rises force reset
// - tap reset leaves memory untouched
// - power-up reset, tdo high impedance
// - three-bit ir, idcode after reset
// - capture-ir loads binary 01 low
// - bypass is one-bit register
`timescale 1ns/100ps
`default_nettype none
`include "sjtap_regs.vh"
module sjtap_port #(
  parameter [31:0] ID_CODE = 32'h0000_1001, // arbitrary identity value
  parameter        BSR_W   = 8
) (
  // system
  input  wire             CORE_CLK,
  input  wire             RESET_N,
  // test pins
  input  wire             TCK,
  input  wire             TMS,
  input  wire             TDI,
  output reg              TDO,
  output reg              TDO_OE,
  // boundary ring
  input  wire [BSR_W-1:0] BSR_CAPTURE,
  output reg  [BSR_W-1:0] BSR_UPDATE,
  output wire             EXTEST_ON,
  output wire             OUT_HIGHZ,
  output wire [2:0]       IR_CURRENT
);
  reg        rst_m;
  reg        rst_n;
  wire       tck_s;
  wire       tms_s;
  wire       tdi_s;
  reg        tck_d;
  reg  [3:0] state;
  reg  [3:0] next_state;
  reg  [2:0] ir_sh;
  reg  [2:0] ir;
  reg        byp;
  reg  [31:0] id_sh;
  reg  [BSR_W-1:0] bsr_sh;
  reg        sel_lsb;
  wire       rise;
  wire       fall;

  always @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rst_m <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_m <= 1'b1;
      rst_n <= rst_m;
    end
  end

  // tms and tdi floating high: pull-ups modelled by reset value high; tck resets low
  sjtap_sync #(.RST_VAL(1'b0)) u_tck (
    .clk(CORE_CLK), .rst_n(rst_n), .d(TCK), .q(tck_s));
  sjtap_sync #(.RST_VAL(1'b1)) u_tms (
    .clk(CORE_CLK), .rst_n(rst_n), .d(TMS), .q(tms_s));
  sjtap_sync #(.RST_VAL(1'b1)) u_tdi (
    .clk(CORE_CLK), .rst_n(rst_n), .d(TDI), .q(tdi_s));

  always @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      tck_d <= 1'b0;
    end else begin
      tck_d <= tck_s;
    end
  end

  // a tck held low never yields an edge, so the tap stays idle
  assign rise = tck_s & ~tck_d;
  assign fall = ~tck_s & tck_d;

  always @* begin
    next_state = state;
    case (state)
      `SJTAP_S_RESET:  next_state = tms_s ? `SJTAP_S_RESET
                                          : `SJTAP_S_IDLE;
      `SJTAP_S_IDLE:   next_state = tms_s ? `SJTAP_S_SEL_DR
                                          : `SJTAP_S_IDLE;
      `SJTAP_S_SEL_DR: next_state = tms_s ? `SJTAP_S_SEL_IR
                                          : `SJTAP_S_CAP_DR;
      `SJTAP_S_CAP_DR: next_state = tms_s ? `SJTAP_S_EX1_DR
                                          : `SJTAP_S_SH_DR;
      `SJTAP_S_SH_DR:  next_state = tms_s ? `SJTAP_S_EX1_DR
                                          : `SJTAP_S_SH_DR;
      `SJTAP_S_EX1_DR: next_state = tms_s ? `SJTAP_S_UPD_DR
                                          : `SJTAP_S_PAU_DR;
      `SJTAP_S_PAU_DR: next_state = tms_s ? `SJTAP_S_EX2_DR
                                          : `SJTAP_S_PAU_DR;
      `SJTAP_S_EX2_DR: next_state = tms_s ? `SJTAP_S_UPD_DR
                                          : `SJTAP_S_SH_DR;
      `SJTAP_S_UPD_DR: next_state = tms_s ? `SJTAP_S_SEL_DR
                                          : `SJTAP_S_IDLE;
      // five tms-high rises reach reset from any state
      `SJTAP_S_SEL_IR: next_state = tms_s ? `SJTAP_S_RESET
                                          : `SJTAP_S_CAP_IR;
      `SJTAP_S_CAP_IR: next_state = tms_s ? `SJTAP_S_EX1_IR
                                          : `SJTAP_S_SH_IR;
      `SJTAP_S_SH_IR:  next_state = tms_s ? `SJTAP_S_EX1_IR
                                          : `SJTAP_S_SH_IR;
      `SJTAP_S_EX1_IR: next_state = tms_s ? `SJTAP_S_UPD_IR
                                          : `SJTAP_S_PAU_IR;
      `SJTAP_S_PAU_IR: next_state = tms_s ? `SJTAP_S_EX2_IR
                                          : `SJTAP_S_PAU_IR;
      `SJTAP_S_EX2_IR: next_state = tms_s ? `SJTAP_S_UPD_IR
                                          : `SJTAP_S_SH_IR;
      `SJTAP_S_UPD_IR: next_state = tms_s ? `SJTAP_S_SEL_DR
                                          : `SJTAP_S_IDLE;
      default:         next_state = `SJTAP_S_RESET;
    endcase
  end

  // tap logic touches only test outputs, never the memory path
  always @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      state      <= `SJTAP_S_RESET;
      ir         <= `SJTAP_IR_IDCODE;
      ir_sh      <= 3'h0;
      byp        <= 1'b0;
      id_sh      <= 32'h0000_0000;
      bsr_sh     <= {BSR_W{1'b0}};
      BSR_UPDATE <= {BSR_W{1'b1}};
    end else if (rise) begin
      state <= next_state;
      case (state)
        `SJTAP_S_RESET: begin
          ir         <= `SJTAP_IR_IDCODE;
          BSR_UPDATE <= {BSR_W{1'b1}};
        end
        `SJTAP_S_CAP_IR: begin
          ir_sh <= {1'b0, `SJTAP_IR_CAPTURE};
        end
        `SJTAP_S_SH_IR: begin
          ir_sh <= {tdi_s, ir_sh[2:1]};
        end
        `SJTAP_S_UPD_IR: begin
          ir <= ir_sh;
        end
        `SJTAP_S_CAP_DR: begin
          byp    <= 1'b0;
          id_sh  <= ID_CODE;
          bsr_sh <= BSR_CAPTURE;
        end
        `SJTAP_S_SH_DR: begin
          // only the register the instruction names moves
          if (ir == `SJTAP_IR_IDCODE) begin
            id_sh <= {tdi_s, id_sh[31:1]};
          end else if (ir == `SJTAP_IR_EXTEST ||
                       ir == `SJTAP_IR_SAMPLE ||
                       ir == `SJTAP_IR_SAMPLEZ) begin
            bsr_sh <= {tdi_s, bsr_sh[BSR_W-1:1]};
          end else begin
            byp <= tdi_s;
          end
        end
        `SJTAP_S_UPD_DR: begin
          if (ir == `SJTAP_IR_EXTEST || ir == `SJTAP_IR_SAMPLE) begin
            BSR_UPDATE <= bsr_sh;
          end
        end
        default: begin
          ir <= ir;
        end
      endcase
      // entering reset restores the idle view at once, not a rise later
      if (next_state == `SJTAP_S_RESET) begin
        ir         <= `SJTAP_IR_IDCODE;
        BSR_UPDATE <= {BSR_W{1'b1}};
      end
    end
  end

  always @* begin
    if (state == `SJTAP_S_SH_IR) begin
      sel_lsb = ir_sh[0];
    end else if (ir == `SJTAP_IR_IDCODE) begin
      sel_lsb = id_sh[0];
    end else if (ir == `SJTAP_IR_EXTEST || ir == `SJTAP_IR_SAMPLE ||
                 ir == `SJTAP_IR_SAMPLEZ) begin
      sel_lsb = bsr_sh[0];
    end else begin
      sel_lsb = byp;
    end
  end

  // output side moves on the falling edge only
  always @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      TDO    <= 1'b0;
      TDO_OE <= 1'b0;
    end else if (fall) begin
      TDO    <= sel_lsb;
      TDO_OE <= (state == `SJTAP_S_SH_IR) ||
                (state == `SJTAP_S_SH_DR);
    end
  end

  assign EXTEST_ON  = (ir == `SJTAP_IR_EXTEST);
  assign OUT_HIGHZ  = (ir == `SJTAP_IR_SAMPLEZ) |
                      (EXTEST_ON & ~BSR_UPDATE[BSR_W-1]);
  assign IR_CURRENT = ir;
endmodule
`default_nettype wire

// ===== tb/sjtap_checker.sv
`timescale 1ns/100ps
`default_nettype none
`include "sjtap_regs.vh"
module sjtap_checker #(
  parameter BSR_W = 8
) (
  input wire logic             CORE_CLK,
  input wire logic             RESET_N,
  input wire logic             TCK,
  input wire logic             TMS,
  input wire logic             TDO,
  input wire logic             TDO_OE,
  input wire logic [BSR_W-1:0] BSR_UPDATE,
  input wire logic             EXTEST_ON,
  input wire logic             OUT_HIGHZ,
  input wire logic [2:0]       IR_CURRENT
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);
  logic       tck_d;
  logic [2:0] ones;
  // tms-high rises seen at the pins, saturating at five
  always @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      tck_d <= 1'b0;
      ones  <= 3'h0;
    end else begin
      tck_d <= TCK;
      if (TCK && !tck_d)
        ones <= !TMS ? 3'h0 : (ones == 3'h5) ? ones : ones + 3'h1;
    end
  end
  sequence s_five; $rose(ones == 3'h5); endsequence
  sequence s_quiet; !TCK [*8]; endsequence
  property p_tdo_fall; $changed(TDO) |-> !$past(TCK) && !$past(TCK, 2);
  endproperty
  property p_oe_fall; $changed(TDO_OE) |-> !$past(TCK) && !$past(TCK, 2);
  endproperty
  property p_oe_hold; $changed(TDO_OE) |=> $stable(TDO_OE) [*8]; endproperty
  property p_rst; $rose(RESET_N) |->
    IR_CURRENT == `SJTAP_IR_IDCODE && !TDO_OE && &BSR_UPDATE; endproperty
  property p_five; s_five |-> !TDO_OE ##[1:6] IR_CURRENT == `SJTAP_IR_IDCODE;
  endproperty
  property p_ext; EXTEST_ON == (IR_CURRENT == `SJTAP_IR_EXTEST); endproperty
  property p_hiz; IR_CURRENT == `SJTAP_IR_SAMPLEZ |-> OUT_HIGHZ; endproperty
  property p_still; s_quiet |->
    $stable(TDO) && $stable(TDO_OE) && $stable(IR_CURRENT); endproperty
  a_tdo_fall: assert property (p_tdo_fall)
    else $error("tdo moved while tck high");
  a_oe_fall: assert property (p_oe_fall)
    else $error("tdo enable moved while tck high");
  a_oe_hold: assert property (p_oe_hold)
    else $error("tdo enable glitch");
  a_rst: assert property (p_rst)
    else $error("bad state after reset");
  a_five: assert property (p_five)
    else $error("five tms-high rises did not reset");
  a_ext: assert property (p_ext)
    else $error("extest flag wrong");
  a_hiz: assert property (p_hiz)
    else $error("output bus not floated");
  a_still: assert property (p_still)
    else $error("outputs moved with tck parked");
endmodule
bind sjtap_port sjtap_checker #(.BSR_W(BSR_W)) sjtap_checker_i (
  .CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .TCK(TCK), .TMS(TMS), .TDO(TDO),
  .TDO_OE(TDO_OE), .BSR_UPDATE(BSR_UPDATE), .EXTEST_ON(EXTEST_ON),
  .OUT_HIGHZ(OUT_HIGHZ), .IR_CURRENT(IR_CURRENT));
`default_nettype wire

// ===== tb/sjtap_ctrl_model.sv
`timescale 1ns/100ps
`default_nettype none
module sjtap_ctrl_model (
  // test pins
  output logic      TCK,
  output logic      TMS,
  output logic      TDI,
  input  wire logic TDO,
  input  wire logic TDO_OE
);
  // between frames the clock is parked low and data lines float high
  initial begin
    TCK = 1'b0;
    TMS = 1'b1;
    TDI = 1'b1;
  end
  // n tck periods, lsb first; a floating tdo reads as unknown
  task automatic frame(input logic [63:0] m, d, input int n,
                       output logic [63:0] q);
    q = 'x;
    // offset keeps every pin edge clear of the core clock edges
    #2.5;
    for (int i = 0; i < n; i++) begin
      TMS = m[i];
      TDI = d[i];
      #60;
      q[i] = TDO_OE ? TDO : 1'bx;
      TCK = 1'b1;
      #65;
      TCK = 1'b0;
    end
    TMS = 1'b1;
    TDI = 1'b1;
  endtask
endmodule
`default_nettype wire

// ===== tb/sjtap_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "sjtap_regs.vh"
module testbench;
  localparam [31:0] ID = 32'h0000_1001; // arbitrary identity value
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        tck, tms, tdi, tdo, tdo_oe, ext_on, hiz;
  logic [7:0]  cap = 8'h3C;
  logic [7:0]  upd;
  logic [2:0]  ir;
  logic [63:0] so;
  int          err_total = 0;
  int          samples_checked = 0;
  always #5 clk = ~clk;
  sjtap_port #(.ID_CODE(ID), .BSR_W(8)) sjtap_port_i (
    .CORE_CLK(clk), .RESET_N(rst_n), .TCK(tck), .TMS(tms), .TDI(tdi),
    .TDO(tdo), .TDO_OE(tdo_oe), .BSR_CAPTURE(cap), .BSR_UPDATE(upd),
    .EXTEST_ON(ext_on), .OUT_HIGHZ(hiz), .IR_CURRENT(ir));
  sjtap_ctrl_model sjtap_ctrl_model_i (.TCK(tck), .TMS(tms), .TDI(tdi),
    .TDO(tdo), .TDO_OE(tdo_oe));
  task automatic end_sim;
    if (err_total == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input logic [63:0] got, exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("Error %0t: %s got %0h want %0h", $time, what, got, exp);
    end
  endtask
  task automatic run(input logic [63:0] m, d, input int n);
    sjtap_ctrl_model_i.frame(m, d, n, so);
    repeat (4) @(negedge clk);
  endtask
  task automatic t_reset;
    check(ir, `SJTAP_IR_IDCODE, "ir after reset");
    check(tdo_oe, 1'b0, "tdo enable after reset");
    check(upd, 8'hFF, "update cells after reset");
  endtask
  task automatic t_idcode;
    run(64'h18_0000_0002, '1, 38);
    check(so[35:4], ID, "identity shift");
    check(tdo_oe, 1'b0, "tdo enable in idle");
  endtask
  task automatic t_ir(input logic [2:0] code);
    run(64'hC3, {57'h0, code, 4'h0}, 9);
    check(so[5:4], 2'h1, "ir capture pattern");
    check(ir, code, "ir load");
    check(ext_on, code == `SJTAP_IR_EXTEST, "extest flag");
    check(hiz, code == `SJTAP_IR_SAMPLEZ, "output float flag");
  endtask
  task automatic t_dr(input logic [2:0] code, input logic [7:0] pat);
    t_ir(code);
    run(64'hC01, {53'h0, pat, 3'h0}, 13);
    if (code == `SJTAP_IR_SAMPLE) begin
      check(so[10:3], cap, "captured ring");
      check(upd, pat, "ring update");
    end else begin
      check(so[10:3], {pat[6:0], 1'b0}, "bypass");
    end
  endtask
  task automatic t_five;
    t_ir(`SJTAP_IR_BYPASS);
    run(64'hF9, '1, 8);
    t_reset();
    // one low tms rise leaves reset for idle before the next scenario
    run(64'h0, '1, 1);
  endtask
  initial begin
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    t_reset();
    t_idcode();
    for (int c = 0; c < 8; c++)
      t_ir(c[2:0]);
    t_dr(`SJTAP_IR_BYPASS, 8'hA5);
    t_dr(3'h5, 8'h96);
    t_dr(`SJTAP_IR_SAMPLE, 8'h5A);
    t_five();
    t_dr(`SJTAP_IR_SAMPLE, 8'hC3);
    // second reset mid-run must restore the idle view
    rst_n = 1'b0;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    t_reset();
    end_sim();
  end
  initial begin
    #100000;
    err_total++;
    end_sim();
  end
endmodule
`default_nettype wire
